/* File: core/tcs_cmd_status.sv */
`timescale 1ns/10ps
// Behaviour
// R1: Reset before transfer reports 01H, step 00H.
// R2: Reset during transfer ends it, 01H step 01H.
// R3: Handshake timeout stops transfer, 2CH step 01H.
// R4: Normal end 60H/02H, or 61H with attention.
// R5: Auto receive after attention, message taken: 62H.
// R6: Send with auto message, buffer busy: 66H.
// R7: Zero byte count refuses command: 65H/01H.
// R8: Receive byte parity error ends: 24H/01H.
// R9: Receive bytes refused, buffer busy: 6CH/01H.
// R10: Receive-message attention always 61H, never 62H.
// R11: Auto message errors use listed step 01H.
// R12: Command during command: result, then 64H.
// R13: Ready source pending at command: then 64H.
// R14: Illegal or out-of-nexus commands: 65H/00H.
// R15: Host register parity error reports 22H/00H.
// R16: Hold report and interrupt until acknowledged.
module tcs_cmd_status
   import tcs_pkg::*;
#(
   parameter int TIMER_W = tcs_pkg::TMR_W
)(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   // Host command port
   input  wire logic                   cmdValid,
   input  wire logic [7:0]             cmdCode,
   input  wire logic [tcs_pkg::CNT_W-1:0] byteCount,
   input  wire logic                   autoRecv,
   input  wire logic [TIMER_W-1:0]     reqAckLimit,
   input  wire logic                   regParityErr,
   input  wire logic                   readyPending,
   input  wire logic                   targetMode,
   input  wire logic                   nexusUp,
   // Transfer engine on the same clock
   input  wire logic                   reqAckWait,
   input  wire logic                   byteDone,
   input  wire logic                   byteParErr,
   input  wire logic                   inBufFull,
   // SCSI pins
   input  wire logic                   busResetPin,
   input  wire logic                   attnPin,
   // Host report
   input  wire logic                   hostAck,
   output      logic                   hostIrq,
   output      logic [7:0]             intCode,
   output      logic [7:0]             stepCode
);
   import tcs_pkg::*;

   tcs_rpt_if rpt ();

   tcs_state_t             state;
   logic [7:0]             opCode;
   logic [CNT_W-1:0]       remaining;
   logic [TIMER_W-1:0]     timer;
   logic [7:0]             rptCode;
   logic [7:0]             rptStep;
   logic [1:0]             pinS1, pinS2, pinS3;
   logic                   busReset, atn;
   logic                   regParPend, deferPend;
   logic                   timeoutHit, isRecv, pushReg, pushCmd, cmdOk;
   logic                   badCmd;

   // ------------------------------------------------------------
   // Pin synchronisers: a level counts once stages two and three agree
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinS1    <= 2'h0;
         pinS2    <= 2'h0;
         pinS3    <= 2'h0;
         busReset <= 1'b0;
         atn      <= 1'b0;
      end else begin
         pinS1 <= {attnPin, busResetPin};
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         if (pinS2[0] == pinS3[0]) begin
            busReset <= pinS2[0];
         end
         if (pinS2[1] == pinS3[1]) begin
            atn <= pinS2[1];
         end
      end
   end

   // ------------------------------------------------------------
   // REQ/ACK timer; a limit of zero turns the check off
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer <= '0;
      end else if ((state != ST_XFER && state != ST_AUTO) || byteDone ||
                   !reqAckWait) begin
         timer <= '0;
      end else if (timer != '1) begin
         timer <= timer + 1'b1;
      end
   end

   assign timeoutHit = (reqAckLimit != '0) && (timer >= reqAckLimit);
   assign isRecv     = (opCode == CMD_RECV_CMD) || (opCode == CMD_RECV_MSG);
   assign cmdOk      = cmdValid && state == ST_IDLE && !readyPending;
   assign badCmd     = !tcs_is_known(cmdCode) ||
                       (cmdCode == CMD_SELECT && targetMode) ||
                       (tcs_is_xfer(cmdCode) && !nexusUp) ||
                       (cmdCode == CMD_RESELECT && nexusUp);

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state     <= ST_IDLE;
         opCode    <= CMD_SEND_MSG;
         remaining <= CNT_ZERO;
         rptCode   <= STEP_0;
         rptStep   <= STEP_0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (cmdOk) begin
                  opCode    <= cmdCode;
                  remaining <= byteCount;
                  if (badCmd) begin
                     state   <= ST_REPORT; // [R14]
                     rptCode <= CODE_REJECT;
                     rptStep <= STEP_0;
                  end else if (tcs_is_xfer(cmdCode) && busReset) begin
                     state   <= ST_REPORT; // [R1]
                     rptCode <= CODE_BUS_RESET;
                     rptStep <= STEP_0;
                  end else if (tcs_is_xfer(cmdCode) && byteCount == CNT_ZERO)
                  begin
                     state   <= ST_REPORT; // [R7]
                     rptCode <= CODE_REJECT;
                     rptStep <= STEP_1;
                  end else if (tcs_is_xfer(cmdCode)) begin
                     state <= ST_XFER;
                  end
               end
            end
            ST_XFER: begin
               if (busReset) begin
                  state   <= ST_REPORT; // [R2]
                  rptCode <= CODE_BUS_RESET;
                  rptStep <= STEP_1;
               end else if (timeoutHit) begin
                  state   <= ST_REPORT; // [R3]
                  rptCode <= CODE_TIMEOUT;
                  rptStep <= STEP_1;
               end else if (byteDone && isRecv && byteParErr) begin
                  state   <= ST_REPORT; // [R8]
                  rptCode <= CODE_SCSI_PAR;
                  rptStep <= STEP_1;
               end else if (byteDone && isRecv && inBufFull) begin
                  state   <= ST_REPORT; // [R9]
                  rptCode <= CODE_RX_BUSY;
                  rptStep <= STEP_1;
               end else if (byteDone && remaining != CNT_ONE) begin
                  remaining <= remaining - 1'b1;
               end else if (byteDone) begin
                  remaining <= CNT_ZERO;
                  rptStep   <= STEP_2;
                  if (!atn) begin
                     state   <= ST_REPORT; // [R4]
                     rptCode <= CODE_DONE;
                  end else if (!autoRecv || opCode == CMD_RECV_MSG) begin
                     state   <= ST_REPORT; // [R4] [R10]
                     rptCode <= CODE_DONE_ATN;
                  end else if (opCode == CMD_SEND_MSG && inBufFull) begin
                     state   <= ST_REPORT; // [R6]
                     rptCode <= CODE_MSG_BUSY;
                  end else begin
                     state <= ST_AUTO;
                  end
               end
            end
            ST_AUTO: begin
               // Errors here use the step of the listed error cases.
               rptStep <= (busReset || timeoutHit || byteParErr) ? STEP_1
                                                                 : STEP_2;
               if (busReset) begin
                  state   <= ST_REPORT;
                  rptCode <= CODE_BUS_RESET;
               end else if (timeoutHit) begin
                  state   <= ST_REPORT;
                  rptCode <= CODE_TIMEOUT;
               end else if (byteDone) begin
                  state   <= ST_REPORT; // [R5] [R11]
                  rptCode <= byteParErr ? CODE_SCSI_PAR : CODE_ATN_MSG;
               end
            end
            ST_REPORT: begin
               if (rpt.free) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pending events; a new event beats the clear in the same cycle
   // ------------------------------------------------------------
   assign pushCmd = state == ST_REPORT && rpt.free;
   assign pushReg = regParPend && rpt.free && state != ST_REPORT;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         regParPend <= 1'b0;
      end else begin
         regParPend <= regParityErr || (regParPend && !pushReg); // [R15]
      end
   end

   // The double-issue report is released only once the sequencer is
   // idle and no ready-state source is outstanding, so it follows them.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         deferPend <= 1'b0;
      end else begin
         deferPend <= (cmdValid && !cmdOk) ||
                      (deferPend && !rpt.setDefer); // [R12] [R13]
      end
   end

   assign rpt.push     = pushCmd || pushReg;
   assign rpt.pushCode = pushCmd ? rptCode : CODE_REG_PAR;
   assign rpt.pushStep = pushCmd ? rptStep : STEP_0;
   assign rpt.setDefer = deferPend && state == ST_IDLE && !readyPending &&
                         !rpt.push && !cmdValid;
   assign rpt.ack      = hostAck;
   assign hostIrq      = rpt.irq;
   assign intCode      = rpt.code;
   assign stepCode     = rpt.step;

   tcs_report_hold u_hold (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .rpt      (rpt.hold)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_xferStart;
      cmdOk && !badCmd && tcs_is_xfer(cmdCode);
   endsequence
   sequence s_lastByte;
      state == ST_XFER && !busReset && !timeoutHit && byteDone &&
      !(isRecv && (byteParErr || inBufFull)) && remaining == CNT_ONE;
   endsequence

   chk_reset_before: assert property (s_xferStart and busReset |=> // [R1]
      rptCode == CODE_BUS_RESET && rptStep == STEP_0 && state == ST_REPORT)
      else $error("reset before transfer misreported");
   chk_reset_during: assert property (state == ST_XFER && busReset |=> // [R2]
      state == ST_REPORT && rptCode == CODE_BUS_RESET && rptStep == STEP_1)
      else $error("reset during transfer misreported");
   chk_timeout_stop: assert property (state == ST_XFER && !busReset && // [R3]
      timeoutHit |=> state == ST_REPORT && rptCode == CODE_TIMEOUT)
      else $error("timeout not reported");
   chk_done_plain: assert property (s_lastByte and !atn |=> // [R4]
      rptCode == CODE_DONE && rptStep == STEP_2)
      else $error("normal end misreported");
   chk_recv_msg_atn: assert property (s_lastByte and atn && // [R10]
      opCode == CMD_RECV_MSG |=> rptCode == CODE_DONE_ATN)
      else $error("receive message attention misreported");
   chk_zero_count: assert property (s_xferStart and !busReset && // [R7]
      byteCount == CNT_ZERO |=> rptCode == CODE_REJECT && rptStep == STEP_1)
      else $error("zero count not refused");
   chk_scsi_parity: assert property (state == ST_XFER && !busReset && // [R8]
      !timeoutHit && byteDone && isRecv && byteParErr |=>
      rptCode == CODE_SCSI_PAR && rptStep == STEP_1)
      else $error("parity error misreported");
   chk_reject_bad: assert property (cmdOk && badCmd |=> // [R14]
      rptCode == CODE_REJECT && rptStep == STEP_0)
      else $error("illegal command not rejected");
   chk_auto_step: assert property (state == ST_AUTO && !busReset && // [R5]
      !timeoutHit && byteDone && !byteParErr |=>
      rptStep == STEP_2 && rptCode == CODE_ATN_MSG)
      else $error("automatic message step wrong");
   chk_double_order: assert property (cmdValid && state == ST_XFER |=> // [R12]
      deferPend && !rpt.setDefer)
      else $error("double issue released too early");
   chk_irq_hold: assert property (hostIrq && !hostAck && !rpt.push |=> // [R16]
      hostIrq && $stable(intCode) && $stable(stepCode))
      else $error("report changed before acknowledge");
   chk_reg_parity: assert property (pushReg |=> // [R15]
      hostIrq && intCode == CODE_REG_PAR && stepCode == STEP_0)
      else $error("register parity report wrong");

endmodule : tcs_cmd_status

/* File: core/tcs_pkg.sv */
package tcs_pkg;

   // ------------------------------------------------------------
   // Report codes and step codes
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_BUS_RESET = 8'h01;
   localparam logic [7:0] CODE_REG_PAR   = 8'h22;
   localparam logic [7:0] CODE_SCSI_PAR  = 8'h24;
   localparam logic [7:0] CODE_TIMEOUT   = 8'h2C;
   localparam logic [7:0] CODE_DONE      = 8'h60;
   localparam logic [7:0] CODE_DONE_ATN  = 8'h61;
   localparam logic [7:0] CODE_ATN_MSG   = 8'h62;
   localparam logic [7:0] CODE_DOUBLE    = 8'h64;
   localparam logic [7:0] CODE_REJECT    = 8'h65;
   localparam logic [7:0] CODE_MSG_BUSY  = 8'h66;
   localparam logic [7:0] CODE_RX_BUSY   = 8'h6C;
   localparam logic [7:0] STEP_0         = 8'h00;
   localparam logic [7:0] STEP_1         = 8'h01;
   localparam logic [7:0] STEP_2         = 8'h02;

   // ------------------------------------------------------------
   // Command codes seen by this block
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_SEND_MSG   = 8'h10;
   localparam logic [7:0] CMD_RECV_CMD   = 8'h11;
   localparam logic [7:0] CMD_RECV_MSG   = 8'h12;
   localparam logic [7:0] CMD_RESELECT   = 8'h20;
   localparam logic [7:0] CMD_SELECT     = 8'h30;

   // ------------------------------------------------------------
   // Widths and byte count constants
   // ------------------------------------------------------------
   localparam int         CNT_W          = 8;
   localparam int         TMR_W          = 16;
   localparam logic [7:0] CNT_ZERO       = 8'h00;
   localparam logic [7:0] CNT_ONE        = 8'h01;

   typedef enum logic [1:0] {
      ST_IDLE, ST_XFER, ST_AUTO, ST_REPORT
   } tcs_state_t;

   function automatic logic tcs_is_xfer(input logic [7:0] c);
      return c == CMD_SEND_MSG || c == CMD_RECV_CMD || c == CMD_RECV_MSG;
   endfunction : tcs_is_xfer

   function automatic logic tcs_is_known(input logic [7:0] c);
      return tcs_is_xfer(c) || c == CMD_RESELECT || c == CMD_SELECT;
   endfunction : tcs_is_known

endpackage : tcs_pkg

/* File: core/tcs_report_hold.sv */
`timescale 1ns/10ps
module tcs_report_hold
   import tcs_pkg::*;
(
   // Clock and reset
   input wire logic  core_clk,
   input wire logic  rst_b,
   // Report channel
   tcs_rpt_if.hold   rpt
);

   logic       mainValid;
   logic       deferValid;
   logic [7:0] mainCode;
   logic [7:0] mainStep;
   logic       next_mainValid;
   logic       next_deferValid;

   // ------------------------------------------------------------
   // One report at a time; the deferred double-issue report waits
   // ------------------------------------------------------------
   always_comb begin
      next_mainValid  = mainValid;
      next_deferValid = deferValid;
      if (rpt.ack && mainValid) begin
         next_mainValid = 1'b0;
      end else if (rpt.ack) begin
         next_deferValid = 1'b0;
      end
      // A new event in the acknowledge cycle is kept, not lost.
      if (rpt.push) begin
         next_mainValid = 1'b1;
      end
      if (rpt.setDefer) begin
         next_deferValid = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mainValid  <= 1'b0;
         deferValid <= 1'b0;
         mainCode   <= STEP_0;
         mainStep   <= STEP_0;
      end else begin
         mainValid  <= next_mainValid;
         deferValid <= next_deferValid;
         if (rpt.push) begin
            mainCode <= rpt.pushCode;
            mainStep <= rpt.pushStep;
         end
      end
   end

   // Main report takes precedence over the deferred one on the outputs. [R16]
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rpt.irq  <= 1'b0;
         rpt.code <= STEP_0;
         rpt.step <= STEP_0;
      end else begin
         rpt.irq  <= next_mainValid || next_deferValid;
         rpt.code <= next_mainValid ? (rpt.push ? rpt.pushCode : mainCode)
                                    : (next_deferValid ? CODE_DOUBLE : STEP_0);
         rpt.step <= next_mainValid ? (rpt.push ? rpt.pushStep : mainStep)
                                    : STEP_0;
      end
   end

   assign rpt.free = !mainValid;

endmodule : tcs_report_hold

/* File: core/tcs_rpt_if.sv */
`timescale 1ns/10ps
interface tcs_rpt_if;
   logic       push;
   logic [7:0] pushCode;
   logic [7:0] pushStep;
   logic       setDefer;
   logic       free;
   logic       ack;
   logic       irq;
   logic [7:0] code;
   logic [7:0] step;

   modport src  (output push, pushCode, pushStep, setDefer, ack,
                 input  free, irq, code, step);
   modport hold (input  push, pushCode, pushStep, setDefer, ack,
                 output free, irq, code, step);
endinterface : tcs_rpt_if

/* File: testbench/tb_tcs_cmd_status.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_tcs_cmd_status;
   import tcs_pkg::*;
   localparam logic [7:0] XFER [3] = '{CMD_SEND_MSG, CMD_RECV_CMD,
                                       CMD_RECV_MSG};
   logic        core_clk, rst_b, cmdValid, autoRecv, regParityErr;
   logic [7:0]  cmdCode, byteCount, intCode, stepCode, nBytes;
   logic [15:0] reqAckLimit;
   logic        readyPending, targetMode, nexusUp, reqAckWait, byteDone;
   logic        byteParErr, inBufFull, busResetPin, attnPin, hostAck;
   logic        hostIrq, go, stall, parLast;
   int          fails, n_tests;

   tcs_cmd_status tcs_cmd_status_i (.core_clk(core_clk), .rst_b(rst_b),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .byteCount(byteCount),
      .autoRecv(autoRecv), .reqAckLimit(reqAckLimit),
      .regParityErr(regParityErr), .readyPending(readyPending),
      .targetMode(targetMode), .nexusUp(nexusUp), .reqAckWait(reqAckWait),
      .byteDone(byteDone), .byteParErr(byteParErr), .inBufFull(inBufFull),
      .busResetPin(busResetPin), .attnPin(attnPin), .hostAck(hostAck),
      .hostIrq(hostIrq), .intCode(intCode), .stepCode(stepCode));
   tcs_init_model tcs_init_model_i (.core_clk(core_clk), .rst_b(rst_b),
      .go(go), .nBytes(nBytes), .stall(stall), .parLast(parLast),
      .byteDone(byteDone), .byteParErr(byteParErr),
      .reqAckWait(reqAckWait));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // A zero byte budget leaves the far side idle.
   task automatic issue(input logic [7:0] code, cnt, nb);
      tick(1);
      cmdValid = 1'b1;
      cmdCode = code;
      byteCount = cnt;
      go = nb != 8'h00;
      nBytes = nb;
      tick(1);
      cmdValid = 1'b0;
      go = 1'b0;
   endtask : issue

   // Clears bytes left over after an aborted transfer.
   task automatic flush;
      go = 1'b1;
      nBytes = 8'h00;
      tick(1);
      go = 1'b0;
   endtask : flush

   task automatic expect_rpt(input logic [7:0] code, step, input bit lo);
      int n;
      n = 0;
      while (hostIrq !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      `CHK(hostIrq, 1'b1)
      `CHK(intCode, code)
      `CHK(stepCode, step)
      tick(3);
      `CHK({hostIrq, intCode, stepCode}, {1'b1, code, step})
      hostAck = 1'b1;
      tick(1);
      hostAck = 1'b0;
      if (lo) `CHK(hostIrq, 1'b0)
   endtask : expect_rpt

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_normal;
      for (int i = 0; i < 3; i++) begin
         issue(XFER[i], 8'h02, 8'h02);
         expect_rpt(CODE_DONE, STEP_2, 1'b1);
      end
      issue(CMD_SEND_MSG, 8'hFF, 8'hFF);
      expect_rpt(CODE_DONE, STEP_2, 1'b1);
   endtask : t_normal

   task automatic t_attn;
      attnPin = 1'b1;
      tick(5);
      issue(CMD_SEND_MSG, 8'h01, 8'h01);
      expect_rpt(CODE_DONE_ATN, STEP_2, 1'b1);
      autoRecv = 1'b1;
      issue(CMD_SEND_MSG, 8'h01, 8'h02);
      expect_rpt(CODE_ATN_MSG, STEP_2, 1'b1);
      issue(CMD_RECV_CMD, 8'h02, 8'h03);
      expect_rpt(CODE_ATN_MSG, STEP_2, 1'b1);
      issue(CMD_RECV_MSG, 8'h01, 8'h01);
      expect_rpt(CODE_DONE_ATN, STEP_2, 1'b1);
      parLast = 1'b1;
      issue(CMD_RECV_CMD, 8'h01, 8'h02);
      expect_rpt(CODE_SCSI_PAR, STEP_1, 1'b1);
      parLast = 1'b0;
      issue(CMD_SEND_MSG, 8'h01, 8'h01);
      tick(12);
      busResetPin = 1'b1;
      expect_rpt(CODE_BUS_RESET, STEP_1, 1'b1);
      busResetPin = 1'b0;
      tick(5);
      inBufFull = 1'b1;
      issue(CMD_SEND_MSG, 8'h01, 8'h01);
      expect_rpt(CODE_MSG_BUSY, STEP_2, 1'b1);
      inBufFull = 1'b0;
      attnPin = 1'b0;
      autoRecv = 1'b0;
      tick(5);
   endtask : t_attn

   task automatic t_errors;
      parLast = 1'b1;
      for (int i = 1; i < 3; i++) begin
         issue(XFER[i], 8'h01, 8'h01);
         expect_rpt(CODE_SCSI_PAR, STEP_1, 1'b1);
      end
      parLast = 1'b0;
      inBufFull = 1'b1;
      for (int i = 1; i < 3; i++) begin
         issue(XFER[i], 8'h01, 8'h01);
         expect_rpt(CODE_RX_BUSY, STEP_1, 1'b1);
      end
      inBufFull = 1'b0;
      for (int i = 0; i < 3; i++) begin
         issue(XFER[i], CNT_ZERO, 8'h00);
         expect_rpt(CODE_REJECT, STEP_1, 1'b1);
      end
   endtask : t_errors

   task automatic t_bus_reset;
      busResetPin = 1'b1;
      tick(5);
      issue(CMD_RECV_CMD, 8'h01, 8'h00);
      expect_rpt(CODE_BUS_RESET, STEP_0, 1'b1);
      busResetPin = 1'b0;
      tick(5);
      stall = 1'b1;
      issue(CMD_SEND_MSG, 8'h02, 8'h02);
      tick(4);
      busResetPin = 1'b1;
      expect_rpt(CODE_BUS_RESET, STEP_1, 1'b1);
      busResetPin = 1'b0;
      stall = 1'b0;
      flush();
      tick(5);
   endtask : t_bus_reset

   task automatic t_timeout;
      stall = 1'b1;
      issue(CMD_RECV_MSG, 8'h02, 8'h02);
      tick(15);
      `CHK(hostIrq, 1'b0)
      expect_rpt(CODE_TIMEOUT, STEP_1, 1'b1);
      stall = 1'b0;
      flush();
   endtask : t_timeout

   task automatic t_double;
      issue(CMD_SEND_MSG, 8'h02, 8'h02);
      issue(CMD_RECV_CMD, 8'h01, 8'h00);
      expect_rpt(CODE_DONE, STEP_2, 1'b0);
      expect_rpt(CODE_DOUBLE, STEP_0, 1'b1);
      readyPending = 1'b1;
      issue(CMD_SEND_MSG, 8'h01, 8'h00);
      tick(5);
      `CHK(hostIrq, 1'b0)
      readyPending = 1'b0;
      expect_rpt(CODE_DOUBLE, STEP_0, 1'b1);
   endtask : t_double

   task automatic t_illegal;
      logic [7:0] codes [4];
      codes = '{8'hFF, CMD_SELECT, CMD_RESELECT, CMD_SEND_MSG};
      for (int i = 0; i < 4; i++) begin
         nexusUp = i != 3;
         issue(codes[i], 8'h01, 8'h00);
         expect_rpt(CODE_REJECT, STEP_0, 1'b1);
      end
      nexusUp = 1'b1;
      targetMode = 1'b0;
      issue(CMD_SELECT, 8'h01, 8'h00);
      tick(5);
      `CHK(hostIrq, 1'b0)
      targetMode = 1'b1;
      regParityErr = 1'b1;
      tick(1);
      regParityErr = 1'b0;
      expect_rpt(CODE_REG_PAR, STEP_0, 1'b1);
   endtask : t_illegal

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // The tests need under two thousand cycles; a hang is cut well after.
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      end_sim();
   end

   initial begin
      {rst_b, cmdValid, autoRecv, regParityErr, readyPending} = 5'h00;
      {inBufFull, busResetPin, attnPin, hostAck, go} = 5'h00;
      {stall, parLast, targetMode, nexusUp} = 4'h3;
      {cmdCode, byteCount, nBytes} = 24'h000000;
      reqAckLimit = 16'h0014;
      fails = 0;
      n_tests = 0;
      tick(8);
      rst_b = 1'b1;
      tick(5);
      t_normal();
      t_attn();
      t_errors();
      t_bus_reset();
      t_timeout();
      t_double();
      t_illegal();
      end_sim();
   end
endmodule : tb_tcs_cmd_status

/* File: testbench/tcs_init_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far side: initiator and byte engine
// ------------------------------------------------------------
// Each byte waits four cycles in handshake before it moves. A stall
// freezes the handshake so the device timer can run out.
module tcs_init_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // Control from the bench
   input  wire logic       go,
   input  wire logic [7:0] nBytes,
   input  wire logic       stall,
   input  wire logic       parLast,
   // Transfer engine side
   output      logic       byteDone,
   output      logic       byteParErr,
   output      logic       reqAckWait
);
   logic [7:0] left;
   logic [2:0] gap;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         left       <= 8'h00;
         gap        <= 3'h0;
         byteDone   <= 1'b0;
         byteParErr <= 1'b0;
         reqAckWait <= 1'b0;
      end else begin
         byteDone   <= 1'b0;
         byteParErr <= 1'b0;
         if (go) begin
            left       <= nBytes;
            gap        <= 3'h3;
            reqAckWait <= nBytes != 8'h00;
         end else if (left != 8'h00 && !stall) begin
            if (gap != 3'h0) begin
               gap <= gap - 3'h1;
            end else begin
               byteDone   <= 1'b1;
               byteParErr <= parLast && left == 8'h01;
               left       <= left - 8'h01;
               gap        <= 3'h3;
               reqAckWait <= left != 8'h01;
            end
         end
      end
   end
endmodule : tcs_init_model
